/* File: logic/bfifo_device.sv */
// How it works
// - Almost-empty flags update on reading clock.
// - Almost-empty low at offset or fewer words.
// - Almost-empty rises on second reading edge.
// - Early edge may defer first sync cycle.
// - Almost-full flags update on writing clock.
// - Almost-full low at depth minus offset.
// - Almost-full rises on second writing edge.
// - Offsets preset at reset, or programmed.
// - Two mailboxes, chosen by mailbox select.
// - Port A mailbox write stores A data.
// - A-to-B mailbox keeps only sized lanes.
// - Port B mailbox write stores sized lanes.
// - Mail write drops full flag; blocks rewrites.
// - Outputs from mailbox, or zero, by select.
// - Port B mailbox read releases A-to-B flag.
// - Port A mailbox read releases B-to-A flag.
// - Reads keep mail; no endian reorder.
// - Bus width applied at master reset end.
// - Endian select caught at reset release.
// - FIFO memories hold 36-bit words only.
// - FIFO2 write and FIFO1 read qualifiers.
//
// The address map and strobed register access were left to the implementer.
module bfifo_device #(
	parameter int DEPTH = bfifo_pkg::DEPTH_DEFAULT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic offset_load,
	input wire logic [1:0] offset_index,
	input wire logic [bfifo_pkg::CNT_W-1:0] offset_value,
	input wire logic fifo1_write,
	input wire logic fifo1_read,
	input wire logic fifo2_write,
	input wire logic fifo2_read,
	output logic [bfifo_pkg::CNT_W-1:0] fifo1_level,
	output logic [bfifo_pkg::CNT_W-1:0] fifo2_level,
	output logic big_endian_active,
	bfifo_if.device port
);
	// ----------------------------------------------------------------
	// Configuration and offsets
	// ----------------------------------------------------------------
	logic [bfifo_pkg::CNT_W-1:0] fifo1_empty_offset_reg, fifo2_empty_offset_reg;
	logic [bfifo_pkg::CNT_W-1:0] fifo1_full_offset_reg, fifo2_full_offset_reg;
	bfifo_pkg::bfifo_size_t size_reg;
	logic mrs_d_reg;
	logic mrs_n;
	logic cfg_done_reg;
	localparam logic [bfifo_pkg::CNT_W-1:0] DEPTH_C = bfifo_pkg::CNT_W'(DEPTH);
	assign mrs_n = port.fifo1_master_reset_n & port.fifo2_master_reset_n;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mrs_d_reg <= 1'b0;
			size_reg <= bfifo_pkg::BFIFO_LONG;
			big_endian_active <= 1'b0;
			cfg_done_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			mrs_d_reg <= mrs_n;
			cfg_done_reg <= mrs_n;
			if (mrs_n && !mrs_d_reg)
			begin
				big_endian_active <= port.big_endian_select;
				if (!port.bus_match_select)
					size_reg <= bfifo_pkg::BFIFO_LONG;
				else if (!port.size_select)
					size_reg <= bfifo_pkg::BFIFO_WORD;
				else
					size_reg <= bfifo_pkg::BFIFO_BYTE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo1_empty_offset_reg <= bfifo_pkg::PRESET_OFFSET;
			fifo1_full_offset_reg <= bfifo_pkg::PRESET_OFFSET;
			fifo2_empty_offset_reg <= bfifo_pkg::PRESET_OFFSET;
			fifo2_full_offset_reg <= bfifo_pkg::PRESET_OFFSET;
		end
		else if (clk_en)
		begin
			if (!mrs_n)
			begin
				fifo1_empty_offset_reg <= bfifo_pkg::PRESET_OFFSET;
				fifo1_full_offset_reg <= bfifo_pkg::PRESET_OFFSET;
				fifo2_empty_offset_reg <= bfifo_pkg::PRESET_OFFSET;
				fifo2_full_offset_reg <= bfifo_pkg::PRESET_OFFSET;
			end
			else if (offset_load)
			begin
				if (offset_index == 2'h0)
					fifo1_full_offset_reg <= offset_value;
				else if (offset_index == 2'h1)
					fifo1_empty_offset_reg <= offset_value;
				else if (offset_index == 2'h2)
					fifo2_full_offset_reg <= offset_value;
				else
					fifo2_empty_offset_reg <= offset_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fill levels of the two 36-bit memories
	// ----------------------------------------------------------------
	// Only whole long words are counted; lane packing lives outside.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fifo1_level <= '0;
			fifo2_level <= '0;
		end
		else if (clk_en)
		begin
			if (!mrs_n)
			begin
				fifo1_level <= '0;
				fifo2_level <= '0;
			end
			else
			begin
				if (fifo1_write && !fifo1_read && fifo1_level != DEPTH_C)
					fifo1_level <= fifo1_level + 1'b1;
				else if (fifo1_read && !fifo1_write && fifo1_level != '0)
					fifo1_level <= fifo1_level - 1'b1;
				if (fifo2_write && !fifo2_read && fifo2_level != DEPTH_C)
					fifo2_level <= fifo2_level + 1'b1;
				else if (fifo2_read && !fifo2_write && fifo2_level != '0)
					fifo2_level <= fifo2_level - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Partial flags through two flip-flop stages
	// ----------------------------------------------------------------
	// Both ports share mclk here; the two stages still give the required
	// second-edge latency, which a true crossing would also need.
	logic [3:0] flag_raw;
	logic [3:0] flag_s1_reg;
	assign flag_raw[0] = fifo1_level > fifo1_empty_offset_reg;
	assign flag_raw[1] = fifo2_level > fifo2_empty_offset_reg;
	assign flag_raw[2] = fifo1_level < DEPTH_C - fifo1_full_offset_reg;
	assign flag_raw[3] = fifo2_level < DEPTH_C - fifo2_full_offset_reg;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Full stages start high so no false almost-full pulse follows reset.
			flag_s1_reg <= 4'hc;
			port.portb_almost_empty_n <= 1'b0;
			port.porta_almost_empty_n <= 1'b0;
			port.porta_almost_full_n <= 1'b1;
			port.portb_almost_full_n <= 1'b1;
		end
		else if (clk_en)
		begin
			flag_s1_reg <= flag_raw;
			port.portb_almost_empty_n <= flag_s1_reg[0];
			port.porta_almost_empty_n <= flag_s1_reg[1];
			port.porta_almost_full_n <= flag_s1_reg[2];
			port.portb_almost_full_n <= flag_s1_reg[3];
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port.portb_full_input_ready <= 1'b0;
			port.portb_empty_output_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			port.portb_full_input_ready <= cfg_done_reg && mrs_n && fifo2_level != DEPTH_C;
			port.portb_empty_output_ready <= mrs_n && fifo1_level != '0;
		end
	end

	// ----------------------------------------------------------------
	// Mailboxes
	// ----------------------------------------------------------------
	logic [35:0] a_to_b_mailbox_reg, b_to_a_mailbox_reg;
	logic [35:0] lane_mask;
	logic a_wr, a_rd, b_wr, b_rd;
	assign lane_mask = (size_reg == bfifo_pkg::BFIFO_LONG) ? 36'hfffffffff :
		(size_reg == bfifo_pkg::BFIFO_WORD) ? 36'h00003ffff : 36'h0000001ff;
	assign a_wr = !port.porta_chip_select_n && port.porta_write_read_sel && port.porta_enable;
	assign a_rd = !port.porta_chip_select_n && !port.porta_write_read_sel && port.porta_enable;
	assign b_wr = !port.portb_chip_select_n && !port.portb_write_read_sel && port.portb_enable;
	assign b_rd = !port.portb_chip_select_n && port.portb_write_read_sel && port.portb_enable;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_to_b_mailbox_reg <= 36'h000000000;
			port.a_to_b_mail_full_n <= 1'b1;
		end
		else if (clk_en)
		begin
			// Mail stays put across reads.
			if (a_wr && port.porta_mailbox_select && port.a_to_b_mail_full_n)
			begin
				a_to_b_mailbox_reg <= port.porta_data_to_dev & lane_mask;
				port.a_to_b_mail_full_n <= 1'b0;
			end
			else if (b_rd && port.portb_mailbox_select)
				port.a_to_b_mail_full_n <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			b_to_a_mailbox_reg <= 36'h000000000;
			port.b_to_a_mail_full_n <= 1'b1;
		end
		else if (clk_en)
		begin
			if (b_wr && port.portb_mailbox_select && port.b_to_a_mail_full_n)
			begin
				b_to_a_mailbox_reg <= port.portb_data_to_dev & lane_mask;
				port.b_to_a_mail_full_n <= 1'b0;
			end
			else if (a_rd && port.porta_mailbox_select)
				port.b_to_a_mail_full_n <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Output drive
	// ----------------------------------------------------------------
	// The FIFO datapath is elsewhere, so its output register reads zero.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port.porta_data_from_dev <= 36'h000000000;
			port.portb_data_from_dev <= 36'h000000000;
			port.porta_data_oe <= 1'b0;
			port.portb_data_oe <= 1'b0;
		end
		else if (clk_en)
		begin
			port.porta_data_oe <= !port.porta_chip_select_n && !port.porta_write_read_sel;
			port.portb_data_oe <= !port.portb_chip_select_n && port.portb_write_read_sel;
			port.porta_data_from_dev <= port.porta_mailbox_select ? b_to_a_mailbox_reg : 36'h000000000;
			port.portb_data_from_dev <= port.portb_mailbox_select ? a_to_b_mailbox_reg : 36'h000000000;
		end
	end
endmodule // bfifo_device

/* File: logic/bfifo_pkg.sv */
package bfifo_pkg;
	localparam int DATA_W = 36;
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;
	localparam int DEPTH_DEFAULT = 2048;
	localparam int CNT_W = 14;
	localparam logic [CNT_W-1:0] PRESET_OFFSET = 14'h0008;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {BFIFO_LONG, BFIFO_WORD, BFIFO_BYTE} bfifo_size_t;
endpackage

/* File: logic/bfifo_if.sv */
interface bfifo_if;
	logic porta_chip_select_n;
	logic porta_write_read_sel;
	logic porta_enable;
	logic porta_mailbox_select;
	logic [35:0] porta_data_to_dev;
	logic [35:0] porta_data_from_dev;
	logic porta_data_oe;
	logic porta_almost_empty_n;
	logic porta_almost_full_n;
	logic b_to_a_mail_full_n;
	logic portb_chip_select_n;
	logic portb_write_read_sel;
	logic portb_enable;
	logic portb_mailbox_select;
	logic [35:0] portb_data_to_dev;
	logic [35:0] portb_data_from_dev;
	logic portb_data_oe;
	logic portb_almost_empty_n;
	logic portb_almost_full_n;
	logic a_to_b_mail_full_n;
	logic portb_full_input_ready;
	logic portb_empty_output_ready;
	logic bus_match_select;
	logic size_select;
	logic big_endian_select;
	logic fifo1_master_reset_n;
	logic fifo2_master_reset_n;
	modport device (
		input porta_chip_select_n, porta_write_read_sel, porta_enable, porta_mailbox_select, porta_data_to_dev,
		input portb_chip_select_n, portb_write_read_sel, portb_enable, portb_mailbox_select, portb_data_to_dev,
		input bus_match_select, size_select, big_endian_select, fifo1_master_reset_n, fifo2_master_reset_n,
		output porta_data_from_dev, porta_data_oe, porta_almost_empty_n, porta_almost_full_n, b_to_a_mail_full_n,
		output portb_data_from_dev, portb_data_oe, portb_almost_empty_n, portb_almost_full_n, a_to_b_mail_full_n,
		output portb_full_input_ready, portb_empty_output_ready
	);
	modport host (
		output porta_chip_select_n, porta_write_read_sel, porta_enable, porta_mailbox_select, porta_data_to_dev,
		output portb_chip_select_n, portb_write_read_sel, portb_enable, portb_mailbox_select, portb_data_to_dev,
		output bus_match_select, size_select, big_endian_select, fifo1_master_reset_n, fifo2_master_reset_n,
		input porta_data_from_dev, porta_data_oe, porta_almost_empty_n, porta_almost_full_n, b_to_a_mail_full_n,
		input portb_data_from_dev, portb_data_oe, portb_almost_empty_n, portb_almost_full_n, a_to_b_mail_full_n,
		input portb_full_input_ready, portb_empty_output_ready
	);
endinterface

/* File: logic/bfifo_host.sv */
module bfifo_host (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic a_mail_write,
	input wire logic a_mail_read,
	input wire logic [35:0] a_mail_data,
	input wire logic b_mail_write,
	input wire logic b_mail_read,
	input wire logic [35:0] b_mail_data,
	input wire logic cfg_bus_match,
	input wire logic cfg_size,
	input wire logic cfg_big_endian,
	input wire logic master_reset,
	output logic [35:0] a_read_data,
	output logic [35:0] b_read_data,
	output logic a_mail_pending_n,
	output logic b_mail_pending_n,
	bfifo_if.host port
);
	// ----------------------------------------------------------------
	// Port strobes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port.porta_chip_select_n <= 1'b1;
			port.porta_write_read_sel <= 1'b0;
			port.porta_enable <= 1'b0;
			port.porta_mailbox_select <= 1'b0;
			port.porta_data_to_dev <= 36'h000000000;
			port.portb_chip_select_n <= 1'b1;
			port.portb_write_read_sel <= 1'b0;
			port.portb_enable <= 1'b0;
			port.portb_mailbox_select <= 1'b0;
			port.portb_data_to_dev <= 36'h000000000;
		end
		else if (clk_en)
		begin
			port.porta_chip_select_n <= !(a_mail_write || a_mail_read);
			port.porta_write_read_sel <= a_mail_write;
			port.porta_enable <= a_mail_write || a_mail_read;
			port.porta_mailbox_select <= a_mail_write || a_mail_read;
			port.porta_data_to_dev <= a_mail_data;
			port.portb_chip_select_n <= !(b_mail_write || b_mail_read);
			port.portb_write_read_sel <= !b_mail_write;
			port.portb_enable <= b_mail_write || b_mail_read;
			port.portb_mailbox_select <= b_mail_write || b_mail_read;
			port.portb_data_to_dev <= b_mail_data;
		end
	end

	// ----------------------------------------------------------------
	// Static configuration and master reset
	// ----------------------------------------------------------------
	// Size levels are held static; endian is sampled by the device.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port.bus_match_select <= 1'b0;
			port.size_select <= 1'b0;
			port.big_endian_select <= 1'b0;
			port.fifo1_master_reset_n <= 1'b0;
			port.fifo2_master_reset_n <= 1'b0;
		end
		else if (clk_en)
		begin
			port.bus_match_select <= cfg_bus_match;
			port.size_select <= cfg_size;
			port.big_endian_select <= cfg_big_endian;
			port.fifo1_master_reset_n <= !master_reset;
			port.fifo2_master_reset_n <= !master_reset;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_read_data <= 36'h000000000;
			b_read_data <= 36'h000000000;
			a_mail_pending_n <= 1'b1;
			b_mail_pending_n <= 1'b1;
		end
		else if (clk_en)
		begin
			a_read_data <= port.porta_data_from_dev;
			b_read_data <= port.portb_data_from_dev;
			a_mail_pending_n <= port.b_to_a_mail_full_n;
			b_mail_pending_n <= port.a_to_b_mail_full_n;
		end
	end
endmodule // bfifo_host

/* File: testbench/bfifo_sva.sv */
module bfifo_sva (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic porta_chip_select_n,
	input wire logic porta_write_read_sel,
	input wire logic porta_enable,
	input wire logic porta_mailbox_select,
	input wire logic [35:0] porta_data_to_dev,
	input wire logic portb_chip_select_n,
	input wire logic portb_write_read_sel,
	input wire logic portb_enable,
	input wire logic portb_mailbox_select,
	input wire logic [35:0] portb_data_from_dev,
	input wire logic portb_data_oe,
	input wire logic a_to_b_mail_full_n,
	input wire logic b_to_a_mail_full_n,
	input wire logic bus_match_select,
	input wire logic size_select,
	input wire logic fifo1_master_reset_n,
	input wire logic fifo2_master_reset_n,
	input wire logic portb_almost_empty_n,
	input wire logic porta_almost_full_n,
	input wire logic portb_full_input_ready
);
	logic a_wr, a_rd, b_wr, b_rd, mr;
	logic [35:0] mask;
	logic [35:0] mail_ab_reg;
	assign a_wr = !porta_chip_select_n && porta_write_read_sel && porta_enable && porta_mailbox_select;
	assign a_rd = !porta_chip_select_n && !porta_write_read_sel && porta_enable && porta_mailbox_select;
	assign b_wr = !portb_chip_select_n && !portb_write_read_sel && portb_enable && portb_mailbox_select;
	assign b_rd = !portb_chip_select_n && portb_write_read_sel && portb_enable && portb_mailbox_select;
	assign mr = fifo1_master_reset_n && fifo2_master_reset_n;
	assign mask = !bus_match_select ? 36'hf_ffff_ffff : (size_select ? 36'h0_0000_01ff : 36'h0_0003_ffff);
	// Shadow copy; a write while mail waits is dropped here as well, so a lost refusal shows up.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			mail_ab_reg <= 36'h0;
		else if (a_wr && a_to_b_mail_full_n && mr)
			mail_ab_reg <= porta_data_to_dev;
	end
	// ---------
	// Properties
	// ---------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	property p_a_store;
		a_wr && a_to_b_mail_full_n && mr |=> !a_to_b_mail_full_n;
	endproperty
	a_a_store: assert property (p_a_store) else $error("a-to-b flag not set");
	property p_b_store;
		b_wr && b_to_a_mail_full_n && mr |=> !b_to_a_mail_full_n;
	endproperty
	a_b_store: assert property (p_b_store) else $error("b-to-a flag not set");
	property p_b_release;
		b_rd && !a_wr && mr |=> a_to_b_mail_full_n;
	endproperty
	a_b_release: assert property (p_b_release) else $error("a-to-b flag not released");
	property p_a_release;
		a_rd && !b_wr && mr |=> b_to_a_mail_full_n;
	endproperty
	a_a_release: assert property (p_a_release) else $error("b-to-a flag not released");
	property p_hold;
		!a_to_b_mail_full_n && !b_rd && mr |=> !a_to_b_mail_full_n;
	endproperty
	a_hold: assert property (p_hold) else $error("a-to-b flag dropped early");
	property p_mail_data;
		portb_data_oe && $past(portb_mailbox_select) && !$past(a_to_b_mail_full_n) |->
			(portb_data_from_dev & mask) == (mail_ab_reg & mask);
	endproperty
	a_mail_data: assert property (p_mail_data) else $error("port b mail data wrong");
	property p_mr_flags;
		!mr [*4] |-> !portb_almost_empty_n && porta_almost_full_n;
	endproperty
	a_mr_flags: assert property (p_mr_flags) else $error("flags wrong in master reset");
	property p_ready;
		$rose(mr) |-> !portb_full_input_ready ##[1:3] portb_full_input_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("input ready late");
endmodule // bfifo_sva

/* File: testbench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, offset_load = 1'b0, big_endian_active;
	logic [1:0] offset_index = 2'h0;
	logic [13:0] offset_value = 14'h0, fifo1_level, fifo2_level;
	logic fifo1_write = 1'b0, fifo1_read = 1'b0, fifo2_write = 1'b0, fifo2_read = 1'b0;
	logic a_mail_write = 1'b0, a_mail_read = 1'b0, b_mail_write = 1'b0, b_mail_read = 1'b0;
	logic [35:0] a_mail_data = 36'h0, b_mail_data = 36'h0, a_seen = 36'h0, b_seen = 36'h0;
	logic [35:0] a_rdata, b_rdata, a_host_seen = 36'h0, b_host_seen = 36'h0;
	logic a_pend_n, b_pend_n, a_oe_q = 1'b0, b_oe_q = 1'b0;
	logic cfg_bus_match = 1'b0, cfg_size = 1'b0, cfg_big_endian = 1'b0, master_reset = 1'b1;
	int n_mismatch = 0;
	int n_checks = 0;
	bfifo_if bif();
	bfifo_device #(.DEPTH(32)) u_bfifo_device (.mclk, .rst_n, .clk_en, .offset_load, .offset_index, .offset_value,
		.fifo1_write, .fifo1_read, .fifo2_write, .fifo2_read, .fifo1_level, .fifo2_level, .big_endian_active, .port(bif));
	bfifo_host u_bfifo_host (.mclk, .rst_n, .clk_en, .a_mail_write, .a_mail_read, .a_mail_data, .b_mail_write,
		.b_mail_read, .b_mail_data, .cfg_bus_match, .cfg_size, .cfg_big_endian, .master_reset, .a_read_data(a_rdata),
		.b_read_data(b_rdata), .a_mail_pending_n(a_pend_n), .b_mail_pending_n(b_pend_n), .port(bif));
	bfifo_sva u_bfifo_sva (.mclk, .rst_n, .porta_chip_select_n(bif.porta_chip_select_n),
		.porta_write_read_sel(bif.porta_write_read_sel), .porta_enable(bif.porta_enable),
		.porta_mailbox_select(bif.porta_mailbox_select), .porta_data_to_dev(bif.porta_data_to_dev),
		.portb_chip_select_n(bif.portb_chip_select_n), .portb_write_read_sel(bif.portb_write_read_sel),
		.portb_enable(bif.portb_enable), .portb_mailbox_select(bif.portb_mailbox_select),
		.portb_data_from_dev(bif.portb_data_from_dev), .portb_data_oe(bif.portb_data_oe),
		.a_to_b_mail_full_n(bif.a_to_b_mail_full_n), .b_to_a_mail_full_n(bif.b_to_a_mail_full_n),
		.bus_match_select(bif.bus_match_select), .size_select(bif.size_select),
		.fifo1_master_reset_n(bif.fifo1_master_reset_n), .fifo2_master_reset_n(bif.fifo2_master_reset_n),
		.portb_almost_empty_n(bif.portb_almost_empty_n), .porta_almost_full_n(bif.porta_almost_full_n),
		.portb_full_input_ready(bif.portb_full_input_ready));
	always #2 mclk = ~mclk;
	// Output enable is registered, so the last enabled cycle carries the mailbox word.
	// The host's registered copy lags the port by one more edge.
	always @(posedge mclk)
	begin
		a_oe_q <= bif.porta_data_oe;
		b_oe_q <= bif.portb_data_oe;
		if (b_oe_q)
			b_host_seen <= b_rdata;
		if (a_oe_q)
			a_host_seen <= a_rdata;
		if (bif.portb_data_oe)
			b_seen <= bif.portb_data_from_dev;
		if (bif.porta_data_oe)
			a_seen <= bif.porta_data_from_dev;
	end
	// ---------
	// Tasks
	// ---------
	task automatic chk(input string what, input logic [35:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic edges(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic mreset(input logic bm, sz, be);
		@(posedge mclk);
		cfg_bus_match <= bm;
		cfg_size <= sz;
		cfg_big_endian <= be;
		master_reset <= 1'b1;
		repeat (6) @(posedge mclk);
		master_reset <= 1'b0;
		edges(6);
		cfg_big_endian <= !be;
		chk("input ready", bif.portb_full_input_ready, 1'b1);
	endtask
	task automatic xfer(input logic b, rd, input logic [35:0] d);
		@(posedge mclk);
		a_mail_write <= !b && !rd;
		b_mail_write <= b && !rd;
		a_mail_read <= !b && rd;
		b_mail_read <= b && rd;
		a_mail_data <= d;
		b_mail_data <= d;
		@(posedge mclk);
		{a_mail_write, b_mail_write, a_mail_read, b_mail_read} <= 4'h0;
		edges(5);
	endtask
	task automatic mail_test(input logic bm, sz, be, input logic [35:0] m);
		mreset(bm, sz, be);
		xfer(1'b0, 1'b0, 36'h9_a5c3_e1f7);
		xfer(1'b0, 1'b0, 36'h6_5a3c_1e08);
		chk("a_to_b flag", bif.a_to_b_mail_full_n, 1'b0);
		chk("b pending", b_pend_n, 1'b0);
		xfer(1'b1, 1'b1, 36'h0);
		chk("b mail data", b_seen & m, 36'h9_a5c3_e1f7 & m);
		chk("b host data", b_host_seen & m, 36'h9_a5c3_e1f7 & m);
		chk("a_to_b flag", bif.a_to_b_mail_full_n, 1'b1);
		xfer(1'b1, 1'b1, 36'h0);
		chk("b mail reread", b_seen & m, 36'h9_a5c3_e1f7 & m);
		xfer(1'b1, 1'b0, 36'hc_3f0f_5a69);
		chk("b_to_a flag", bif.b_to_a_mail_full_n, 1'b0);
		xfer(1'b0, 1'b1, 36'h0);
		chk("a mail data", a_seen & m, 36'hc_3f0f_5a69 & m);
		chk("b_to_a flag", bif.b_to_a_mail_full_n, 1'b1);
		chk("a host data", a_host_seen & m, 36'hc_3f0f_5a69 & m);
		chk("a pending", a_pend_n, 1'b1);
		chk("endian", big_endian_active, be);
		$display("mail test bm %0d size %0d done", bm, sz);
	endtask
	task automatic pulse(input logic f2, rd, input int n);
		repeat (n)
		begin
			@(posedge mclk);
			fifo1_write <= !f2 && !rd;
			fifo1_read <= !f2 && rd;
			fifo2_write <= f2 && !rd;
			fifo2_read <= f2 && rd;
			@(posedge mclk);
			{fifo1_write, fifo1_read, fifo2_write, fifo2_read} <= 4'h0;
		end
	endtask
	function automatic logic ae(input logic f2);
		return f2 ? bif.porta_almost_empty_n : bif.portb_almost_empty_n;
	endfunction
	function automatic logic af(input logic f2);
		return f2 ? bif.portb_almost_full_n : bif.porta_almost_full_n;
	endfunction
	task automatic flags(input logic f2, input int x, y);
		pulse(f2, 1'b0, x);
		edges(4);
		chk("almost empty", ae(f2), 1'b0);
		pulse(f2, 1'b0, 1);
		edges(1);
		chk("almost empty early", ae(f2), 1'b0);
		edges(2);
		chk("almost empty", ae(f2), 1'b1);
		pulse(f2, 1'b0, 30 - x - y);
		edges(4);
		chk("almost full", af(f2), 1'b1);
		pulse(f2, 1'b0, 1);
		edges(4);
		chk("almost full", af(f2), 1'b0);
		chk("level", f2 ? fifo2_level : fifo1_level, 36'(32 - y));
		pulse(f2, 1'b1, 1);
		edges(1);
		chk("almost full early", af(f2), 1'b0);
		edges(2);
		chk("almost full", af(f2), 1'b1);
		$display("flag test fifo %0d done", f2);
	endtask
	task automatic offset(input logic [1:0] idx, input logic [13:0] v);
		@(posedge mclk);
		offset_load <= 1'b1;
		offset_index <= idx;
		offset_value <= v;
		@(posedge mclk);
		offset_load <= 1'b0;
	endtask
	// ---------
	// Sequence
	// ---------
	initial
	begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		mail_test(1'b0, 1'b1, 1'b1, 36'hf_ffff_ffff);
		mail_test(1'b1, 1'b0, 1'b1, 36'h0_0003_ffff);
		mail_test(1'b1, 1'b1, 1'b0, 36'h0_0000_01ff);
		flags(1'b0, 8, 8);
		chk("output ready", bif.portb_empty_output_ready, 1'b1);
		offset(2'h3, 14'h2);
		offset(2'h2, 14'h4);
		flags(1'b1, 2, 4);
		@(posedge mclk);
		clk_en <= 1'b0;
		pulse(1'b1, 1'b1, 2);
		edges(4);
		chk("frozen level", fifo2_level, 36'(32 - 4 - 1));
		chk("frozen flag", af(1'b1), 1'b1);
		@(posedge mclk);
		clk_en <= 1'b1;
		pulse(1'b1, 1'b1, 1);
		edges(2);
		chk("thawed level", fifo2_level, 36'(32 - 4 - 2));
		$display("clock enable test done");
		close_out();
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		close_out();
	end
endmodule // testbench
